/* verilog/rtf_pkg.sv */
package rtf_pkg;
   // buffer geometry
   localparam int unsigned DEPTH      = 128;
   localparam int unsigned AW         = 7;
   localparam int unsigned CW         = 8;
   // host access address and command framing
   localparam logic [7:0]  FIFO_ADDR  = 8'hFF;
   localparam logic [7:0]  CMD_HEADER = 8'h80;
   localparam logic [7:0]  CMD_ABORT  = 8'h67;
   localparam logic [7:0]  CMD_FLUSH_RX = 8'h71;
   localparam logic [7:0]  CMD_FLUSH_TX = 8'h72;
   // transmit almost-full field carries the threshold plus this offset
   localparam logic [7:0]  TX_AF_OFFSET = 8'h02;
   // status bit positions in the main controller state word
   localparam int unsigned ST_FULL_BIT  = 9;
   localparam int unsigned ST_EMPTY_BIT = 8;
   // reset values
   localparam logic [CW-1:0] COUNT_RST = 8'h00;
   localparam logic [AW-1:0] PTR_RST   = 7'h00;
   localparam logic [7:0]    BYTE_RST  = 8'h00;
   // conditions seen just after reset: both buffers empty, so no empty event follows reset
   localparam logic [8:0]    COND_RST  = 9'h020;
   // radio state machine
   typedef enum logic [2:0] {
      RS_READY = 3'b001,
      RS_TX    = 3'b010,
      RS_RX    = 3'b100
   } rtf_radio_type;
endpackage : rtf_pkg

/* verilog/rtf_mem.sv */
`timescale 1ns/1ns
// simple dual port byte memory with registered read data
module rtf_mem
   import rtf_pkg::*;
(
   input  wire logic          clk_i,
   input  wire logic          wr_en_i,
   input  wire logic [AW-1:0] wr_addr_i,
   input  wire logic [7:0]    wr_data_i,
   input  wire logic          rd_en_i,
   input  wire logic [AW-1:0] rd_addr_i,
   output logic      [7:0]    rd_data_o
);
   logic [7:0] mem [DEPTH];

   // storage write, no reset so contents stay undefined until written; a flush only clears pointers
   always_ff @(posedge clk_i)
   begin
      if (wr_en_i)
      begin
         mem[wr_addr_i] <= wr_data_i;
      end
   end

   // registered read port
   always_ff @(posedge clk_i)
   begin
      if (rd_en_i)
      begin
         rd_data_o <= mem[rd_addr_i];
      end
   end
endmodule : rtf_mem

/* verilog/rtf_fifo.sv */
`timescale 1ns/1ns
// Operation
// - two separate 128-byte transmit and receive buffers
// - fixed address 0xFF maps onto both buffers
// - transmit free count hits level-minus-two: event
// - transmit occupancy drains to almost-empty: event
// - receive free count hits level: event
// - receive occupancy drains to almost-empty: event
// - direction bit selects receive or transmit thresholds
// - separate overflow and underflow events per buffer
// - transmit underflow repeats last byte sent
// - retransmit stored packet when retries above zero
// - retransmit only for packets fitting buffer
// - flush commands empty the matching buffer
// - full/empty on state bits nine and eight
// - sleep keeps contents only in retention mode
// - commands act at transfer end immediately
// - abort returns transmit or receive to ready
module rtf_fifo
   import rtf_pkg::*;
(
   input  wire logic       CLK_I,
   input  wire logic       RST_B_I,
   // host access, already decoded to bytes by the serial front end
   input  wire logic       HOST_WR_I,
   input  wire logic       HOST_RD_I,
   input  wire logic [7:0] HOST_ADDR_I,
   input  wire logic [7:0] HOST_WDATA_I,
   output logic      [7:0] HOST_RDATA_O,
   input  wire logic       CMD_VALID_I,
   input  wire logic [7:0] CMD_HDR_I,
   input  wire logic [7:0] CMD_CODE_I,
   // radio control
   input  wire logic       TX_START_I,
   input  wire logic       RX_START_I,
   input  wire logic       PKT_END_I,
   input  wire logic       SLEEP_I,
   input  wire logic       SLEEP_RETAIN_I,
   // configuration
   input  wire logic [7:0] TRANSMIT_ALMOST_FULL_LEVEL_I,
   input  wire logic [7:0] TRANSMIT_ALMOST_EMPTY_LEVEL_I,
   input  wire logic [7:0] RECEIVE_ALMOST_FULL_LEVEL_I,
   input  wire logic [7:0] RECEIVE_ALMOST_EMPTY_LEVEL_I,
   input  wire logic       THRESHOLD_IRQ_DIRECTION_SELECT_I,
   input  wire logic [3:0] MAX_RETRANSMISSION_COUNT_I,
   // packet engine side
   input  wire logic       ENG_TX_RD_I,
   output logic      [7:0] ENG_TX_DATA_O,
   input  wire logic       ENG_RX_WR_I,
   input  wire logic [7:0] ENG_RX_DATA_I,
   // status and events
   output logic [9:8]      MAIN_CONTROLLER_STATE_O,
   output logic            RADIO_READY_O,
   output logic            RADIO_TX_O,
   output logic            RADIO_RX_O,
   output logic [7:0]      TX_COUNT_O,
   output logic [7:0]      RX_COUNT_O,
   output logic            TX_AF_EVT_O,
   output logic            TX_AE_EVT_O,
   output logic            RX_AF_EVT_O,
   output logic            RX_AE_EVT_O,
   output logic            TX_OVF_EVT_O,
   output logic            TX_UNF_EVT_O,
   output logic            RX_OVF_EVT_O,
   output logic            RX_UNF_EVT_O,
   output logic            FULL_EVT_O,
   output logic            EMPTY_EVT_O
);
   logic [CW-1:0]  tx_cnt_q, rx_cnt_q;
   logic [AW-1:0]  tx_wp_q, tx_rp_q, tx_base_q, rx_wp_q, rx_rp_q;
   logic [7:0]     tx_last_q;
   logic           tx_rd_act_q;
   logic           loaded_q;
   logic [7:0]     tx_mem_q, rx_mem_q;
   rtf_radio_type  state_q;
   logic           cmd_ok, flush_tx, flush_rx, abort, lose;
   logic           h_wr, h_rd, tx_push, tx_pop, rx_push, rx_pop;
   logic           tx_ovf, tx_unf, rx_ovf, rx_unf, retx;
   logic [CW-1:0]  tx_free, rx_free;
   logic [8:0]     cond_d, cond_q;

   // true when a count equals a level given as a byte
   function automatic logic at_level(input logic [CW-1:0] c, input logic [7:0] lvl);
      at_level = (c == lvl);
   endfunction : at_level

   // header byte qualifies the command code
   assign cmd_ok   = CMD_VALID_I && (CMD_HDR_I == CMD_HEADER);
   // act in the cycle the transfer completes
   assign flush_tx = cmd_ok && (CMD_CODE_I == CMD_FLUSH_TX);
   assign flush_rx = cmd_ok && (CMD_CODE_I == CMD_FLUSH_RX);
   assign abort    = cmd_ok && (CMD_CODE_I == CMD_ABORT);
   // sleep without retention drops the contents
   assign lose     = SLEEP_I && !SLEEP_RETAIN_I;

   // only the fixed address reaches the buffers
   assign h_wr = HOST_WR_I && (HOST_ADDR_I == FIFO_ADDR);
   assign h_rd = HOST_RD_I && (HOST_ADDR_I == FIFO_ADDR);

   // reads on empty transmit buffer keep the last byte
   assign tx_push = h_wr && (tx_cnt_q != CW'(DEPTH));
   assign tx_pop  = ENG_TX_RD_I && (tx_cnt_q != COUNT_RST);
   assign rx_push = ENG_RX_WR_I && (rx_cnt_q != CW'(DEPTH));
   assign rx_pop  = h_rd && (rx_cnt_q != COUNT_RST);
   // error detection per buffer and direction
   assign tx_ovf  = h_wr && (tx_cnt_q == CW'(DEPTH));
   assign tx_unf  = ENG_TX_RD_I && (tx_cnt_q == COUNT_RST);
   assign rx_ovf  = ENG_RX_WR_I && (rx_cnt_q == CW'(DEPTH));
   assign rx_unf  = h_rd && (rx_cnt_q == COUNT_RST);

   // rewind when retries allowed and nothing new loaded
   // rewind point is the first byte still held
   assign retx = TX_START_I && (state_q == RS_READY) && (tx_cnt_q == COUNT_RST)
                 && (MAX_RETRANSMISSION_COUNT_I != 4'h0) && !loaded_q;

   rtf_mem u_tx_mem
   (
      .clk_i     (CLK_I),
      .wr_en_i   (tx_push),
      .wr_addr_i (tx_wp_q),
      .wr_data_i (HOST_WDATA_I),
      .rd_en_i   (tx_pop),
      .rd_addr_i (tx_rp_q),
      .rd_data_o (tx_mem_q)
   );

   rtf_mem u_rx_mem
   (
      .clk_i     (CLK_I),
      .wr_en_i   (rx_push),
      .wr_addr_i (rx_wp_q),
      .wr_data_i (ENG_RX_DATA_I),
      .rd_en_i   (rx_pop),
      .rd_addr_i (rx_rp_q),
      .rd_data_o (rx_mem_q)
   );

   // radio state for the abort command
   always_ff @(posedge CLK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
         state_q <= RS_READY;
      else
      begin
         unique case (state_q)
            RS_READY:
            begin
               if (TX_START_I)
                  state_q <= RS_TX;
               else if (RX_START_I)
                  state_q <= RS_RX;
            end
            RS_TX, RS_RX:
            begin
               if (abort || PKT_END_I)
                  state_q <= RS_READY;
            end
            default: state_q <= RS_READY;
         endcase
      end
   end

   // transmit pointers and occupancy
   always_ff @(posedge CLK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
      begin
         tx_wp_q   <= PTR_RST;
         tx_rp_q   <= PTR_RST;
         tx_base_q <= PTR_RST;
         tx_cnt_q  <= COUNT_RST;
         loaded_q  <= 1'b0;
      end
      else if (flush_tx || lose)
      begin
         tx_wp_q   <= PTR_RST;
         tx_rp_q   <= PTR_RST;
         tx_base_q <= PTR_RST;
         tx_cnt_q  <= COUNT_RST;
         loaded_q  <= 1'b0;
      end
      else if (retx)
      begin
         tx_rp_q  <= tx_base_q;
         tx_cnt_q <= CW'(tx_wp_q - tx_base_q) | (tx_wp_q == tx_base_q ? 8'h80 : 8'h00);
         loaded_q <= 1'b0;
      end
      else
      begin
         if (tx_push)
            tx_wp_q <= tx_wp_q + 7'h01;
         if (tx_pop)
            tx_rp_q <= tx_rp_q + 7'h01;
         // new packet marks the base and blocks retransmission
         if (tx_push && tx_cnt_q == COUNT_RST)
            tx_base_q <= tx_wp_q;
         if (tx_push)
            loaded_q <= 1'b1;
         else if (TX_START_I)
            loaded_q <= 1'b0;
         tx_cnt_q <= tx_cnt_q + CW'(tx_push) - CW'(tx_pop);
      end
   end

   // receive pointers and occupancy
   always_ff @(posedge CLK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
      begin
         rx_wp_q  <= PTR_RST;
         rx_rp_q  <= PTR_RST;
         rx_cnt_q <= COUNT_RST;
      end
      else if (flush_rx || lose)
      begin
         rx_wp_q  <= PTR_RST;
         rx_rp_q  <= PTR_RST;
         rx_cnt_q <= COUNT_RST;
      end
      else
      begin
         if (rx_push)
            rx_wp_q <= rx_wp_q + 7'h01;
         if (rx_pop)
            rx_rp_q <= rx_rp_q + 7'h01;
         rx_cnt_q <= rx_cnt_q + CW'(rx_push) - CW'(rx_pop);
      end
   end

   // remember whether the engine has a fresh byte
   always_ff @(posedge CLK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
      begin
         tx_rd_act_q <= 1'b0;
         tx_last_q   <= BYTE_RST;
      end
      else
      begin
         tx_rd_act_q <= tx_pop;
         if (tx_rd_act_q)
            tx_last_q <= tx_mem_q;
      end
   end

   assign tx_free = CW'(DEPTH) - tx_cnt_q;
   assign rx_free = CW'(DEPTH) - rx_cnt_q;

   // level conditions gated by direction select; full and empty conditions are not gated
   always_comb
   begin
      cond_d = 9'h000;
      // direction bit picks the active thresholds
      if (!THRESHOLD_IRQ_DIRECTION_SELECT_I)
      begin
         cond_d[0] = at_level(tx_free, TRANSMIT_ALMOST_FULL_LEVEL_I - TX_AF_OFFSET);
         cond_d[1] = at_level(tx_cnt_q, TRANSMIT_ALMOST_EMPTY_LEVEL_I);
      end
      else
      begin
         // free count equals the programmed level
         cond_d[2] = at_level(rx_free, RECEIVE_ALMOST_FULL_LEVEL_I);
         cond_d[3] = at_level(rx_cnt_q, RECEIVE_ALMOST_EMPTY_LEVEL_I);
      end
      cond_d[4] = (tx_cnt_q == CW'(DEPTH)) || (rx_cnt_q == CW'(DEPTH));
      cond_d[5] = (tx_cnt_q == COUNT_RST) || (rx_cnt_q == COUNT_RST);
      cond_d[8:6] = 3'b000;
   end

   // edge detect so each level, full or empty event is one pulse
   always_ff @(posedge CLK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
         cond_q <= COND_RST;
      else
         cond_q <= cond_d;
   end

   // registered event and status outputs
   always_ff @(posedge CLK_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
      begin
         TX_AF_EVT_O  <= 1'b0;
         TX_AE_EVT_O  <= 1'b0;
         RX_AF_EVT_O  <= 1'b0;
         RX_AE_EVT_O  <= 1'b0;
         FULL_EVT_O   <= 1'b0;
         EMPTY_EVT_O  <= 1'b0;
         TX_OVF_EVT_O <= 1'b0;
         TX_UNF_EVT_O <= 1'b0;
         RX_OVF_EVT_O <= 1'b0;
         RX_UNF_EVT_O <= 1'b0;
         MAIN_CONTROLLER_STATE_O <= 2'b01;
      end
      else
      begin
         TX_AF_EVT_O  <= cond_d[0] && !cond_q[0];
         TX_AE_EVT_O  <= cond_d[1] && !cond_q[1];
         RX_AF_EVT_O  <= cond_d[2] && !cond_q[2];
         RX_AE_EVT_O  <= cond_d[3] && !cond_q[3];
         // status bits and matching events together
         FULL_EVT_O   <= cond_d[4] && !cond_q[4];
         EMPTY_EVT_O  <= cond_d[5] && !cond_q[5];
         MAIN_CONTROLLER_STATE_O[ST_FULL_BIT]  <= cond_d[4];
         MAIN_CONTROLLER_STATE_O[ST_EMPTY_BIT] <= cond_d[5];
         TX_OVF_EVT_O <= tx_ovf;
         TX_UNF_EVT_O <= tx_unf;
         RX_OVF_EVT_O <= rx_ovf;
         RX_UNF_EVT_O <= rx_unf;
      end
   end

   // data toward the host and engine
   assign HOST_RDATA_O  = rx_mem_q;
   // empty buffer repeats the last byte sent
   assign ENG_TX_DATA_O = tx_rd_act_q ? tx_mem_q : tx_last_q;
   assign TX_COUNT_O    = tx_cnt_q;
   assign RX_COUNT_O    = rx_cnt_q;
   assign RADIO_READY_O = (state_q == RS_READY);
   assign RADIO_TX_O    = (state_q == RS_TX);
   assign RADIO_RX_O    = (state_q == RS_RX);
endmodule : rtf_fifo

/* sim/rtf_fifo_chk.sv */
`timescale 1ns/1ns
// port checks of the fifo pair
module rtf_fifo_chk
   import rtf_pkg::*;
(
   input wire logic       CLK_I,
   input wire logic       RST_B_I,
   input wire logic       HOST_WR_I,
   input wire logic       HOST_RD_I,
   input wire logic [7:0] HOST_ADDR_I,
   input wire logic       CMD_VALID_I,
   input wire logic [7:0] CMD_HDR_I,
   input wire logic [7:0] CMD_CODE_I,
   input wire logic       SLEEP_I,
   input wire logic [9:8] MAIN_CONTROLLER_STATE_O,
   input wire logic       RADIO_READY_O,
   input wire logic [7:0] TX_COUNT_O,
   input wire logic [7:0] RX_COUNT_O,
   input wire logic       RX_AF_EVT_O,
   input wire logic       TX_OVF_EVT_O,
   input wire logic       RX_UNF_EVT_O
);
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (!RST_B_I);
   // decoded accesses, commands kept apart
   logic hw, hr, cv;
   assign hw = HOST_WR_I && HOST_ADDR_I == FIFO_ADDR && !CMD_VALID_I && !SLEEP_I;
   assign hr = HOST_RD_I && HOST_ADDR_I == FIFO_ADDR && !CMD_VALID_I;
   assign cv = CMD_VALID_I && CMD_HDR_I == CMD_HEADER;
   a_tx_first_write :
      assert property (hw && TX_COUNT_O == 8'h00 |=> TX_COUNT_O == 8'h01)
      else $error("tx count missed a write");
   a_tx_overflow :
      assert property (hw && TX_COUNT_O == 8'h80 |=> TX_OVF_EVT_O)
      else $error("tx overflow not flagged");
   a_rx_underflow :
      assert property (hr && RX_COUNT_O == 8'h00 |=> RX_UNF_EVT_O)
      else $error("rx underflow not flagged");
   a_tx_flush :
      assert property (cv && CMD_CODE_I == CMD_FLUSH_TX |=> TX_COUNT_O == 8'h00)
      else $error("tx flush left data");
   a_rx_flush :
      assert property (cv && CMD_CODE_I == CMD_FLUSH_RX |=> RX_COUNT_O == 8'h00)
      else $error("rx flush left data");
   a_abort_ready :
      assert property (cv && CMD_CODE_I == CMD_ABORT |=> RADIO_READY_O)
      else $error("abort did not reach ready");
   a_full_status :
      assert property ((TX_COUNT_O == 8'h80 || RX_COUNT_O == 8'h80) [*2]
                       |-> MAIN_CONTROLLER_STATE_O[9])
      else $error("full bit missing");
   a_empty_status :
      assert property ((TX_COUNT_O == 8'h00 || RX_COUNT_O == 8'h00) [*2]
                       |-> MAIN_CONTROLLER_STATE_O[8])
      else $error("empty bit missing");
   a_rx_af_single :
      assert property (RX_AF_EVT_O |=> !RX_AF_EVT_O)
      else $error("rx almost full repeated");
   // main scenarios reached
   c_tx_overflow : cover property (TX_OVF_EVT_O);
   c_rx_underflow : cover property (RX_UNF_EVT_O);
   c_rx_almost_full : cover property (RX_AF_EVT_O);
endmodule : rtf_fifo_chk

bind rtf_fifo rtf_fifo_chk u_rtf_fifo_chk (.*);

/* sim/rtf_host.sv */
`timescale 1ns/1ns
// host model: buffer byte accesses and commands
module rtf_host
   import rtf_pkg::*;
(
   input  wire logic       clk_i,
   output logic            wr_o,
   output logic            rd_o,
   output logic      [7:0] addr_o,
   output logic      [7:0] wdata_o,
   output logic            cmd_o,
   output logic      [7:0] hdr_o,
   output logic      [7:0] code_o
);
   // idle at time zero
   initial
   begin
      {wr_o, rd_o, cmd_o} = 3'h0;
      {addr_o, wdata_o, hdr_o, code_o} = 32'h0;
   end
   // reads only when told
   // one byte access, h keeps the strobe up
   task automatic acc(input logic w, input logic [7:0] a, d, input logic h);
      addr_o = a;
      wdata_o = d;
      wr_o = w;
      rd_o = !w;
      @(posedge clk_i);
      #1;
      if (!h)
      begin
         wr_o = 1'b0;
         rd_o = 1'b0;
         wdata_o = ~d;
      end
   endtask : acc
   // header then code
   // command pulse, then one quiet cycle
   task automatic cmd(input logic [7:0] h, c);
      hdr_o = h;
      code_o = c;
      cmd_o = 1'b1;
      @(posedge clk_i);
      #1;
      cmd_o = 1'b0;
      @(posedge clk_i);
      #1;
   endtask : cmd
   task automatic recover(input logic [7:0] f);
      cmd(CMD_HEADER, CMD_ABORT);
      cmd(CMD_HEADER, f);
   endtask : recover
endmodule : rtf_host

/* sim/rtf_fifo_tb.sv */
`timescale 1ns/1ns
// self-checking bench of the fifo pair
module rtf_fifo_tb
   import rtf_pkg::*;
;
   logic CLK_I, RST_B_I, HOST_WR_I, HOST_RD_I, CMD_VALID_I, TX_START_I, RX_START_I;
   logic PKT_END_I, SLEEP_I, SLEEP_RETAIN_I, THRESHOLD_IRQ_DIRECTION_SELECT_I;
   logic ENG_TX_RD_I, ENG_RX_WR_I, RADIO_READY_O, RADIO_TX_O, RADIO_RX_O;
   logic TX_AF_EVT_O, TX_AE_EVT_O, RX_AF_EVT_O, RX_AE_EVT_O, TX_OVF_EVT_O;
   logic TX_UNF_EVT_O, RX_OVF_EVT_O, RX_UNF_EVT_O, FULL_EVT_O, EMPTY_EVT_O;
   logic [7:0] HOST_ADDR_I, HOST_WDATA_I, HOST_RDATA_O, CMD_HDR_I, CMD_CODE_I;
   logic [7:0] TRANSMIT_ALMOST_FULL_LEVEL_I, TRANSMIT_ALMOST_EMPTY_LEVEL_I;
   logic [7:0] RECEIVE_ALMOST_FULL_LEVEL_I, RECEIVE_ALMOST_EMPTY_LEVEL_I;
   logic [7:0] ENG_TX_DATA_O, ENG_RX_DATA_I, TX_COUNT_O, RX_COUNT_O, lastb;
   logic [3:0] MAX_RETRANSMISSION_COUNT_I;
   logic [9:8] MAIN_CONTROLLER_STATE_O;
   logic [9:0] evs;
   logic [7:0] txq[$], rxq[$], pkt[$];
   int         ev[10];
   int         fails = 0;
   int         compares = 0;
   int unsigned seed = 18;

   rtf_fifo u_rtf_fifo (.*);
   rtf_host u_rtf_host (.clk_i(CLK_I), .wr_o(HOST_WR_I), .rd_o(HOST_RD_I),
      .addr_o(HOST_ADDR_I), .wdata_o(HOST_WDATA_I), .cmd_o(CMD_VALID_I),
      .hdr_o(CMD_HDR_I), .code_o(CMD_CODE_I));

   // clock
   initial
   begin
      CLK_I = 1'b0;
      forever #5 CLK_I = ~CLK_I;
   end
   // event pulse tallies
   assign evs = {EMPTY_EVT_O, FULL_EVT_O, RX_UNF_EVT_O, RX_OVF_EVT_O, TX_UNF_EVT_O,
                 TX_OVF_EVT_O, RX_AE_EVT_O, RX_AF_EVT_O, TX_AE_EVT_O, TX_AF_EVT_O};
   always @(negedge CLK_I)
      for (int k = 0; k < 10; k++)
         ev[k] += int'(evs[k] === 1'b1);

   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction : rnd
   task automatic tick(input int n = 1);
      repeat (n)
      begin
         @(posedge CLK_I);
         #1;
      end
   endtask : tick
   task automatic chk(input string n, input logic [7:0] e, g);
      compares++;
      if (g !== e)
      begin
         fails++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask : chk
   // packet engine side access, h keeps the strobe up
   task automatic eng(input logic r, input logic [7:0] d, input logic h);
      ENG_TX_RD_I = r;
      ENG_RX_WR_I = !r;
      ENG_RX_DATA_I = d;
      tick();
      if (!h)
      begin
         ENG_TX_RD_I = 1'b0;
         ENG_RX_WR_I = 1'b0;
      end
   endtask : eng
   // back-to-back bursts against the queue model
   task automatic htx(input int n);
      logic [7:0] d;
      for (int i = 0; i < n; i++)
      begin
         d = rnd();
         txq.push_back(d);
         u_rtf_host.acc(1'b1, FIFO_ADDR, d, i < n - 1);
      end
   endtask : htx
   task automatic erx(input int n);
      logic [7:0] d;
      for (int i = 0; i < n; i++)
      begin
         d = rnd();
         rxq.push_back(d);
         eng(1'b0, d, i < n - 1);
      end
   endtask : erx
   task automatic dtx(input int n);
      for (int i = 0; i < n; i++)
      begin
         eng(1'b1, 8'h00, i < n - 1);
         lastb = txq.pop_front();
         chk("tx data", lastb, ENG_TX_DATA_O);
      end
   endtask : dtx
   task automatic hrx(input int n);
      for (int i = 0; i < n; i++)
      begin
         u_rtf_host.acc(1'b0, FIFO_ADDR, 8'h00, i < n - 1);
         chk("rx data", rxq.pop_front(), HOST_RDATA_O);
      end
   endtask : hrx
   task automatic summarize();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : summarize

   // hang guard
   initial
   begin
      repeat (20000) @(posedge CLK_I);
      fails++;
      summarize();
   end
   // scenarios
   initial
   begin
      {TX_START_I, RX_START_I, PKT_END_I, SLEEP_I, SLEEP_RETAIN_I} = 5'h00;
      {ENG_TX_RD_I, ENG_RX_WR_I, ENG_RX_DATA_I} = 10'h000;
      {TRANSMIT_ALMOST_FULL_LEVEL_I, TRANSMIT_ALMOST_EMPTY_LEVEL_I} = 16'h0A04;
      {RECEIVE_ALMOST_FULL_LEVEL_I, RECEIVE_ALMOST_EMPTY_LEVEL_I} = 16'h0604;
      THRESHOLD_IRQ_DIRECTION_SELECT_I = 1'b0;
      MAX_RETRANSMISSION_COUNT_I = 4'h3;
      RST_B_I = 1'b0;
      repeat (12) @(posedge CLK_I);
      #1;
      RST_B_I = 1'b1;
      chk("state", 8'h01, {6'h00, MAIN_CONTROLLER_STATE_O});
      // transmit fill, stray address ignored
      ev = '{default: 0};
      u_rtf_host.acc(1'b1, 8'hFE, 8'h55, 1'b0);
      tick();
      htx(128);
      tick(3);
      chk("tx count", 8'h80, TX_COUNT_O);
      chk("full bit", 8'h01, {7'h00, MAIN_CONTROLLER_STATE_O[9]});
      chk("tx af", 8'h01, 8'(ev[0]));
      chk("full evt", 8'h01, 8'(ev[8]));
      TX_START_I = 1'b1;
      tick();
      TX_START_I = 1'b0;
      chk("tx state", 8'h01, {7'h00, RADIO_TX_O});
      // drain, then underflow repeats last byte
      ev = '{default: 0};
      dtx(128);
      tick();
      eng(1'b1, 8'h00, 1'b0);
      tick(3);
      chk("tx ae", 8'h01, 8'(ev[1]));
      chk("tx unf", 8'h01, 8'(ev[5]));
      chk("tx repeat", lastb, ENG_TX_DATA_O);
      u_rtf_host.recover(CMD_FLUSH_TX);
      chk("tx abort", 8'h01, {7'h00, RADIO_READY_O});
      // receive side with its thresholds selected
      THRESHOLD_IRQ_DIRECTION_SELECT_I = 1'b1;
      ev = '{default: 0};
      RX_START_I = 1'b1;
      tick();
      RX_START_I = 1'b0;
      chk("rx state", 8'h01, {7'h00, RADIO_RX_O});
      erx(128);
      tick();
      eng(1'b0, 8'hAA, 1'b0);
      tick(3);
      chk("rx af", 8'h01, 8'(ev[2]));
      chk("rx ovf", 8'h01, 8'(ev[6]));
      ev = '{default: 0};
      hrx(128);
      tick();
      u_rtf_host.acc(1'b0, FIFO_ADDR, 8'h00, 1'b0);
      tick(3);
      chk("rx ae", 8'h01, 8'(ev[3]));
      chk("rx unf", 8'h01, 8'(ev[7]));
      u_rtf_host.recover(CMD_FLUSH_RX);
      chk("rx abort", 8'h01, {7'h00, RADIO_READY_O});
      // masked transmit thresholds, overflow, command framing
      ev = '{default: 0};
      htx(128);
      tick();
      u_rtf_host.acc(1'b1, FIFO_ADDR, 8'hAA, 1'b0);
      tick(3);
      chk("tx af masked", 8'h00, 8'(ev[0]));
      chk("tx ovf", 8'h01, 8'(ev[4]));
      // both buffers hold data, so the flush below raises the empty event
      erx(3);
      u_rtf_host.cmd(8'h00, CMD_FLUSH_TX);
      chk("bad header", 8'h80, TX_COUNT_O);
      u_rtf_host.cmd(CMD_HEADER, CMD_FLUSH_TX);
      chk("tx flush", 8'h00, TX_COUNT_O);
      tick();
      chk("empty evt", 8'h01, 8'(ev[9]));
      txq.delete();
      u_rtf_host.cmd(CMD_HEADER, CMD_FLUSH_RX);
      chk("rx flush", 8'h00, RX_COUNT_O);
      rxq.delete();
      // stored packet sent again, then abort
      htx(5);
      pkt = txq;
      TX_START_I = 1'b1;
      tick();
      TX_START_I = 1'b0;
      dtx(5);
      PKT_END_I = 1'b1;
      tick();
      PKT_END_I = 1'b0;
      TX_START_I = 1'b1;
      tick();
      TX_START_I = 1'b0;
      chk("retx count", 8'(pkt.size()), TX_COUNT_O);
      txq = pkt;
      dtx(5);
      // no retries allowed: a new start must not rewind
      PKT_END_I = 1'b1;
      tick();
      {PKT_END_I, TX_START_I} = 2'b01;
      MAX_RETRANSMISSION_COUNT_I = 4'h0;
      tick();
      TX_START_I = 1'b0;
      chk("no retx", 8'h00, TX_COUNT_O);
      u_rtf_host.cmd(CMD_HEADER, CMD_ABORT);
      chk("abort", 8'h01, {7'h00, RADIO_READY_O});
      // sleep keeps contents only with retention
      htx(3);
      {SLEEP_I, SLEEP_RETAIN_I} = 2'h3;
      tick(3);
      chk("retained", 8'h03, TX_COUNT_O);
      SLEEP_RETAIN_I = 1'b0;
      tick(2);
      chk("lost", 8'h00, TX_COUNT_O);
      SLEEP_I = 1'b0;
      summarize();
   end
endmodule : rtf_fifo_tb
